//--- hw/vgaac_pkg.sv
package vgaac_pkg;

    // ==========================================================
    // host port addresses
    localparam logic [15:0] VGAAC_PORT_WR = 16'h03c0;
    localparam logic [15:0] VGAAC_PORT_RD = 16'h03c1;
    localparam logic [15:0] VGAAC_STAT_MONO = 16'h03ba;
    localparam logic [15:0] VGAAC_STAT_COLOR = 16'h03da;

    // ==========================================================
    // attribute index space
    localparam logic [4:0] VGAAC_IDX_PAL_LAST = 5'h0f;
    localparam logic [4:0] VGAAC_IDX_MODE = 5'h10;
    localparam logic [4:0] VGAAC_IDX_OVERSCAN = 5'h11;
    localparam logic [4:0] VGAAC_IDX_PLANE_EN = 5'h12;
    localparam logic [4:0] VGAAC_IDX_HSHIFT = 5'h13;
    localparam logic [4:0] VGAAC_IDX_UPPER = 5'h14;

    // ==========================================================
    // field positions
    localparam int VGAAC_IX_SRC = 5;
    localparam int VGAAC_MC_UPPER_SEL = 7;
    localparam int VGAAC_MC_WIDE = 6;
    localparam int VGAAC_MC_PAN_CMP = 5;
    localparam int VGAAC_MC_BLINK = 3;
    localparam int VGAAC_MC_LINE_GFX = 2;
    localparam int VGAAC_MC_MONO = 1;
    localparam int VGAAC_MC_GRAPHICS = 0;

    // ==========================================================
    // reset values and sizes
    localparam logic [5:0] VGAAC_INDEX_RST = 6'h00;
    localparam logic [7:0] VGAAC_REG_RST = 8'h00;
    localparam logic [5:0] VGAAC_PAL_RST = 6'h00;
    localparam logic [3:0] VGAAC_PAN_RST = 4'h0;
    localparam int VGAAC_PAL_N = 16;
    localparam int VGAAC_FIFO_DEPTH = 8;

    typedef enum logic
    {
        VGAAC_SEL_INDEX = 1'b0,
        VGAAC_SEL_DATA = 1'b1
    } vgaac_sel_e;

    // one dot as delivered by the sequencer side
    typedef struct packed
    {
        logic [3:0] planes;
        logic [3:0] bg;
        logic [7:0] wide_byte;
        logic ninth;
        logic lg_code;
        logic attr_msb;
        logic border;
        logic line_cmp;
        logic vsync;
    } vgaac_pix_s;

    typedef struct packed
    {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } vgaac_io_s;

endpackage

//--- hw/vgaac_top.sv
`timescale 1ns/10ps

// ==========================================================
// pixel fifo
module vgaac_fifo
    import vgaac_pkg::*;
#(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    wire push = in_valid && ready_r;
    wire pop = out_valid && out_ready;

    assign in_ready = ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rptr_r];

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clk_en && push)
        begin
            mem[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
        end
        else if (clk_en)
        begin
            wptr_r <= push ? wptr_r + 1'b1 : wptr_r;
            rptr_r <= pop ? rptr_r + 1'b1 : rptr_r;
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt < (AW+1)'(DEPTH));
        end
    end
endmodule

// ==========================================================
// attribute controller
// Operation
// [R1] index and data are written at one port, read back one higher
// [R2] reading input status register 1 returns the toggle to index
// [R3] a write after an index write loads the indexed data register
// [R4] every write toggles index/data; reads never toggle it
// [R5] index bits 4:0 select; source bit 0 blanks video for palette access
// [R6] sixteen six-bit palette entries drive video bits 5:0
// [R7] mode control at 10, overscan at 11, plane enable at 12
// [R8] mode bit 7 takes video bits 5:4 from upper colour bits 1:0
// [R9] mode bit 6 enables wide 256-colour pixels
// [R10] mode bit 5 lets line compare stop panning until vertical sync
// [R11] mode bit 3 picks blink instead of background intensity
// [R12] mode bit 2 repeats the eighth dot as ninth for line graphics
// [R13] mode bit 1 picks monochrome adapter attributes over colour
// [R14] overscan byte drives all eight video bits in the border
// [R15] host writes zero to overscan for a monochrome display
// [R16] plane enable bits 5:4 route two video bits to status bits 5:4
// [R17] plane enable bits 3:0 gate each colour plane
// [R18] host writes zero into reserved bits
// [R19] status port address follows miscellaneous output bit 0
// [R20] upper colour bits 3:2 drive video bits 7:6 outside 256 colour
// [R21] masked planes pick the palette entry each dot
// [R22] the toggle selects the index after reset
module vgaac_top
    import vgaac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire vgaac_io_s io_req,
    output logic [7:0] io_rdata,
    output logic io_rdata_vld,
    input wire logic misc_color_emul,
    input wire logic blink_phase,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire vgaac_pix_s pix_data,
    output logic vid_valid,
    input wire logic vid_ready,
    output logic video_out_bit7,
    output logic video_out_bit6,
    output logic video_out_bit5,
    output logic video_out_bit4,
    output logic video_out_bit3,
    output logic video_out_bit2,
    output logic video_out_bit1,
    output logic video_out_bit0,
    output logic [1:0] status_video_bits,
    output logic [3:0] pan_shift,
    output logic pixel_wide,
    output logic blink_select,
    output logic line_gfx_enable,
    output logic monochrome_adapter_compat,
    output logic graphics_mode
);
    // ==========================================================
    // register state
    vgaac_sel_e sel_r;
    vgaac_sel_e sel_nxt;
    logic [5:0] index_r;
    logic [5:0] palette_r [VGAAC_PAL_N];
    logic [7:0] mode_r;
    logic [7:0] overscan_r;
    logic [7:0] plane_en_r;
    logic [3:0] hshift_r;
    logic [3:0] upper_r;
    logic [7:0] rdata_r;
    logic rdata_vld_r;

    // ==========================================================
    // host decode
    logic [15:0] stat_addr;
    logic wr_port;
    logic rd_index;
    logic rd_data;
    logic rd_status;
    logic wr_index;
    logic wr_data;
    logic [4:0] sel_idx;
    logic is_pal;
    logic [7:0] data_rd;

    // [R19] status address follows emulation
    assign stat_addr = misc_color_emul ? VGAAC_STAT_COLOR : VGAAC_STAT_MONO;
    // [R1] write port and read port
    assign wr_port = io_req.wr && (io_req.addr == VGAAC_PORT_WR);
    assign rd_index = io_req.rd && (io_req.addr == VGAAC_PORT_WR);
    assign rd_data = io_req.rd && (io_req.addr == VGAAC_PORT_RD);
    assign rd_status = io_req.rd && (io_req.addr == stat_addr);
    // [R3] toggle picks index or data
    assign wr_index = wr_port && (sel_r == VGAAC_SEL_INDEX);
    assign wr_data = wr_port && (sel_r == VGAAC_SEL_DATA);
    // [R5] index low bits select the register
    assign sel_idx = index_r[4:0];
    assign is_pal = (sel_idx <= VGAAC_IDX_PAL_LAST);

    always_comb
    begin
        sel_nxt = sel_r;
        // [R4] write toggles, index and data reads leave it
        if (wr_port)
        begin
            sel_nxt = (sel_r == VGAAC_SEL_INDEX) ? VGAAC_SEL_DATA
                                                 : VGAAC_SEL_INDEX;
        end
        // [R2] status read clears the toggle
        if (rd_status)
        begin
            sel_nxt = VGAAC_SEL_INDEX;
        end
    end

    always_comb
    begin
        data_rd = 8'h00;
        if (is_pal)
        begin
            data_rd = {2'b00, palette_r[sel_idx[3:0]]};
        end
        else
        begin
            unique case (sel_idx)
                VGAAC_IDX_MODE: data_rd = mode_r;
                VGAAC_IDX_OVERSCAN: data_rd = overscan_r;
                VGAAC_IDX_PLANE_EN: data_rd = plane_en_r;
                VGAAC_IDX_HSHIFT: data_rd = {4'h0, hshift_r};
                VGAAC_IDX_UPPER: data_rd = {4'h0, upper_r};
                default: data_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // [R22] index selected out of reset
            sel_r <= VGAAC_SEL_INDEX;
            index_r <= VGAAC_INDEX_RST;
            mode_r <= VGAAC_REG_RST;
            overscan_r <= VGAAC_REG_RST;
            plane_en_r <= VGAAC_REG_RST;
            hshift_r <= VGAAC_PAN_RST;
            upper_r <= VGAAC_PAN_RST;
            rdata_r <= VGAAC_REG_RST;
            rdata_vld_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_r <= sel_nxt;
            rdata_vld_r <= rd_index || rd_data;
            if (rd_index)
            begin
                rdata_r <= {2'b00, index_r};
            end
            else if (rd_data)
            begin
                rdata_r <= data_rd;
            end
            if (wr_index)
            begin
                index_r <= io_req.wdata[5:0];
            end
            // [R7] data register decode
            if (wr_data && (sel_idx == VGAAC_IDX_MODE))
            begin
                mode_r <= io_req.wdata;
            end
            if (wr_data && (sel_idx == VGAAC_IDX_OVERSCAN))
            begin
                overscan_r <= io_req.wdata;
            end
            if (wr_data && (sel_idx == VGAAC_IDX_PLANE_EN))
            begin
                plane_en_r <= {2'b00, io_req.wdata[5:0]};
            end
            if (wr_data && (sel_idx == VGAAC_IDX_HSHIFT))
            begin
                hshift_r <= io_req.wdata[3:0];
            end
            if (wr_data && (sel_idx == VGAAC_IDX_UPPER))
            begin
                upper_r <= io_req.wdata[3:0];
            end
        end
    end

    // ==========================================================
    // palette entries
    genvar gi;
    generate
        for (gi = 0; gi < VGAAC_PAL_N; gi = gi + 1)
        begin : g_pal
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    palette_r[gi] <= VGAAC_PAL_RST;
                end
                // [R6] six colour bits per entry
                else if (clk_en && wr_data && is_pal &&
                         (sel_idx[3:0] == 4'(gi)))
                begin
                    palette_r[gi] <= io_req.wdata[5:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // pixel buffer
    logic fifo_valid;
    logic fifo_pop;
    vgaac_pix_s fp;

    vgaac_fifo #(
        .WIDTH($bits(vgaac_pix_s)),
        .DEPTH(VGAAC_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(pix_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fp)
    );

    // ==========================================================
    // colour translation
    logic [7:0] video_r;
    logic vid_valid_r;
    logic [3:0] last_planes_r;
    logic cmp_hold_r;
    logic [1:0] stat_r;
    logic [3:0] pan_r;
    logic [3:0] masked;
    logic [3:0] ninth_val;
    logic blink_off;
    logic [3:0] pal_sel;
    logic [5:0] pal_out;
    logic [7:0] vid_std;
    logic [7:0] vid_mix;
    logic [7:0] vid_nxt;
    logic [1:0] stat_nxt;
    logic cmp_hold_nxt;

    assign fifo_pop = fifo_valid && (!vid_valid_r || vid_ready);
    // [R17] plane gating
    assign masked = fp.planes & plane_en_r[3:0];
    // [R12] ninth dot repeats eighth or takes background
    assign ninth_val = (mode_r[VGAAC_MC_LINE_GFX] && fp.lg_code)
                       ? last_planes_r : fp.bg;
    // [R11] blink selection hides foreground in off phase
    assign blink_off = mode_r[VGAAC_MC_BLINK] && fp.attr_msb && !blink_phase;
    // [R21] masked planes address the palette
    assign pal_sel = fp.ninth ? ninth_val : (blink_off ? fp.bg : masked);
    assign pal_out = palette_r[pal_sel];
    // [R8] upper colour substitution for bits 5:4
    // [R20] upper colour bits drive bits 7:6
    assign vid_std = {upper_r[3:2],
                      mode_r[VGAAC_MC_UPPER_SEL] ? upper_r[1:0] : pal_out[5:4],
                      pal_out[3:0]};
    // [R9] wide pixels bypass the palette
    assign vid_mix = mode_r[VGAAC_MC_WIDE] ? fp.wide_byte : vid_std;
    // [R5] source bit low blanks; [R14] border takes overscan
    assign vid_nxt = !index_r[VGAAC_IX_SRC] ? 8'h00 :
                     fp.border ? overscan_r : vid_mix;

    // [R16] status routing
    always_comb
    begin
        unique case (plane_en_r[5:4])
            2'b00: stat_nxt = {video_r[2], video_r[0]};
            2'b01: stat_nxt = {video_r[5], video_r[4]};
            2'b10: stat_nxt = {video_r[3], video_r[1]};
            2'b11: stat_nxt = {video_r[7], video_r[6]};
        endcase
    end

    // [R10] line compare holds panning off until vertical sync
    always_comb
    begin
        cmp_hold_nxt = cmp_hold_r;
        if (fifo_pop && fp.vsync)
        begin
            cmp_hold_nxt = 1'b0;
        end
        else if (fifo_pop && fp.line_cmp && mode_r[VGAAC_MC_PAN_CMP])
        begin
            cmp_hold_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            video_r <= 8'h00;
            vid_valid_r <= 1'b0;
            last_planes_r <= 4'h0;
            cmp_hold_r <= 1'b0;
            stat_r <= 2'b00;
            pan_r <= VGAAC_PAN_RST;
        end
        else if (clk_en)
        begin
            cmp_hold_r <= cmp_hold_nxt;
            stat_r <= stat_nxt;
            pan_r <= cmp_hold_nxt ? VGAAC_PAN_RST : hshift_r;
            if (fifo_pop)
            begin
                video_r <= vid_nxt;
                vid_valid_r <= 1'b1;
                last_planes_r <= fp.ninth ? last_planes_r : masked;
            end
            else if (vid_ready)
            begin
                vid_valid_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // outputs
    logic [4:0] flags_r;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_r <= 5'h00;
        end
        else if (clk_en)
        begin
            // [R13] attribute interpretation flags
            flags_r <= {mode_r[VGAAC_MC_WIDE], mode_r[VGAAC_MC_BLINK],
                        mode_r[VGAAC_MC_LINE_GFX], mode_r[VGAAC_MC_MONO],
                        mode_r[VGAAC_MC_GRAPHICS]};
        end
    end

    assign pixel_wide = flags_r[4];
    assign blink_select = flags_r[3];
    assign line_gfx_enable = flags_r[2];
    assign monochrome_adapter_compat = flags_r[1];
    assign graphics_mode = flags_r[0];
    assign io_rdata = rdata_r;
    assign io_rdata_vld = rdata_vld_r;
    assign vid_valid = vid_valid_r;
    assign status_video_bits = stat_r;
    assign pan_shift = pan_r;
    assign video_out_bit7 = video_r[7];
    assign video_out_bit6 = video_r[6];
    assign video_out_bit5 = video_r[5];
    assign video_out_bit4 = video_r[4];
    assign video_out_bit3 = video_r[3];
    assign video_out_bit2 = video_r[2];
    assign video_out_bit1 = video_r[1];
    assign video_out_bit0 = video_r[0];
endmodule

//--- test/vgaac_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// host processor model on the io bus
module vgaac_host_model
    import vgaac_pkg::*;
(
    input logic clk_sys,
    input logic [7:0] io_rdata,
    input logic io_rdata_vld,
    output vgaac_io_s io_req
);
    initial
    begin
        io_req = '{16'hfc3f, 1'b0, 1'b0, 8'hff};
    end

    task automatic acc(input logic [15:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] q, output logic v);
        io_req = '{a, w, !w, d};
        @(negedge clk_sys);
        q = io_rdata;
        v = io_rdata_vld;
    endtask

    // released lines show the inverse of the last request
    task automatic idle();
        io_req = '{~io_req.addr, 1'b0, 1'b0, ~io_req.wdata};
        @(negedge clk_sys);
    endtask
endmodule

//--- test/vgaac_top_asserts.sv
`timescale 1ns/10ps

// ==========================================================
// port checks for the attribute controller
module vgaac_top_asserts
    import vgaac_pkg::*;
(
    input logic clk_sys,
    input logic sys_rst,
    input logic clk_en,
    input vgaac_io_s io_req,
    input logic [7:0] io_rdata,
    input logic io_rdata_vld,
    input logic misc_color_emul,
    input logic vid_valid,
    input logic vid_ready,
    input logic video_out_bit7,
    input logic video_out_bit6,
    input logic video_out_bit5,
    input logic video_out_bit4,
    input logic video_out_bit3,
    input logic video_out_bit2,
    input logic video_out_bit1,
    input logic video_out_bit0,
    input logic [1:0] status_video_bits
);
    logic tog_r;
    logic [5:0] idx_r;
    logic [7:0] mode_r, ovs_r, pen_r, exp_rd;
    logic [1:0] lo_cnt, stat_exp;
    wire [7:0] vid = {video_out_bit7, video_out_bit6, video_out_bit5,
        video_out_bit4, video_out_bit3, video_out_bit2, video_out_bit1,
        video_out_bit0};
    wire [15:0] st_addr = misc_color_emul ? VGAAC_STAT_COLOR
        : VGAAC_STAT_MONO;
    wire io_rd = clk_en && io_req.rd;
    wire wr_port = clk_en && io_req.wr && io_req.addr == VGAAC_PORT_WR;
    wire rd_wr = io_rd && io_req.addr == VGAAC_PORT_WR;
    wire rd_rd = io_rd && io_req.addr == VGAAC_PORT_RD;
    wire rd_any = rd_wr || rd_rd;
    wire stat_rd = io_rd && io_req.addr == st_addr;
    wire [4:0] sel = idx_r[4:0];
    wire dwr = wr_port && tog_r;

    assign exp_rd = sel == VGAAC_IDX_MODE ? mode_r
        : sel == VGAAC_IDX_OVERSCAN ? ovs_r : pen_r;
    assign stat_exp = pen_r[5:4] == 2'h0 ? {vid[2], vid[0]}
        : pen_r[5:4] == 2'h1 ? {vid[5], vid[4]}
        : pen_r[5:4] == 2'h2 ? {vid[3], vid[1]} : {vid[7], vid[6]};

    // ==========================================================
    // shadow of the host-visible state
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tog_r <= 1'b0;
            idx_r <= 6'h00;
            mode_r <= 8'h00;
            ovs_r <= 8'h00;
            pen_r <= 8'h00;
            lo_cnt <= 2'h0;
        end
        else if (clk_en)
        begin
            tog_r <= stat_rd ? 1'b0 : tog_r ^ wr_port;
            if (wr_port && !tog_r)
                idx_r <= io_req.wdata[5:0];
            if (dwr && sel == VGAAC_IDX_MODE)
                mode_r <= io_req.wdata;
            if (dwr && sel == VGAAC_IDX_OVERSCAN)
                ovs_r <= io_req.wdata;
            if (dwr && sel == VGAAC_IDX_PLANE_EN)
                pen_r <= io_req.wdata & 8'h3f;
            if (idx_r[VGAAC_IX_SRC])
                lo_cnt <= 2'h0;
            else if (lo_cnt != 2'h3)
                lo_cnt <= lo_cnt + 2'h1;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_RD_ANSWER:
    assert property (rd_any |=> io_rdata_vld) else $error("no read answer");
    AST_RD_CAUSE:
    assert property ($past(clk_en) && io_rdata_vld |-> $past(rd_any))
        else $error("read answer without read");
    AST_RD_STANDS:
    assert property (clk_en && !rd_any |=> $stable(io_rdata))
        else $error("read data moved without read");
    AST_RD_INDEX:
    assert property (rd_wr |=> io_rdata == {2'h0, $past(idx_r)})
        else $error("index readback wrong");
    AST_RD_DATA:
    assert property (rd_rd && sel inside {5'h10, 5'h11, 5'h12}
        |=> io_rdata == $past(exp_rd)) else $error("register readback wrong");
    AST_STATUS_SEL:
    assert property (clk_en |=> status_video_bits == $past(stat_exp))
        else $error("status video bits wrong");
    AST_BLANK:
    assert property (vid_valid && lo_cnt >= 2'h2 |-> vid == 8'h00)
        else $error("video not blanked");
    AST_VID_HOLD:
    assert property (clk_en && vid_valid && !vid_ready
        |=> vid_valid && $stable(vid)) else $error("video dropped early");
endmodule

bind vgaac_top vgaac_top_asserts chk (.*);

//--- test/test_vgaac_top.sv
`timescale 1ns/10ps

// ==========================================================
// self-checking bench for the attribute controller
module test_vgaac_top
    import vgaac_pkg::*;
;
    localparam logic [15:0] PW = VGAAC_PORT_WR;
    localparam logic [15:0] PR = VGAAC_PORT_RD;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic misc_color_emul = 1'b0;
    logic pix_valid = 1'b0;
    logic vid_ready = 1'b0;
    vgaac_pix_s pix_data = '0;
    wire vgaac_io_s io_req;
    wire [7:0] io_rdata, vid;
    wire io_rdata_vld, pix_ready, vid_valid;
    wire [3:0] pan_shift;
    wire [1:0] stat_bits;
    int num_errors = 0;
    int samples_checked = 0;

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    vgaac_top dut
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(1'b1),
        .io_req(io_req),
        .io_rdata(io_rdata),
        .io_rdata_vld(io_rdata_vld),
        .misc_color_emul(misc_color_emul),
        .blink_phase(1'b1),
        .pix_valid(pix_valid),
        .pix_ready(pix_ready),
        .pix_data(pix_data),
        .vid_valid(vid_valid),
        .vid_ready(vid_ready),
        .video_out_bit7(vid[7]),
        .video_out_bit6(vid[6]),
        .video_out_bit5(vid[5]),
        .video_out_bit4(vid[4]),
        .video_out_bit3(vid[3]),
        .video_out_bit2(vid[2]),
        .video_out_bit1(vid[1]),
        .video_out_bit0(vid[0]),
        .status_video_bits(stat_bits),
        .pan_shift(pan_shift),
        .pixel_wide(),
        .blink_select(),
        .line_gfx_enable(),
        .monochrome_adapter_compat(),
        .graphics_mode()
    );

    vgaac_host_model host
    (
        .clk_sys(clk_sys),
        .io_rdata(io_rdata),
        .io_rdata_vld(io_rdata_vld),
        .io_req(io_req)
    );

    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] s);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        host.acc(a, 1'b1, d, q, v);
    endtask

    task automatic stat(input logic [15:0] a);
        logic [7:0] q;
        logic v;
        host.acc(a, 1'b0, 8'h00, q, v);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic v;
        host.acc(a, 1'b0, 8'h00, q, v);
        host.idle();
        chk("rdata_vld", 8'h01, {7'h00, v});
        chk("rdata", e, q);
    endtask

    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        wr(PW, i);
        wr(PW, d);
        host.idle();
    endtask

    // push one dot, wait for its video and take it
    task automatic dot(input logic [3:0] pl, input logic brd,
        input logic [7:0] wb, input logic lc, input logic vs,
        input logic [7:0] e);
        int n;
        pix_data = '{pl, 4'h0, wb, 1'b0, 1'b0, 1'b0, brd, lc, vs};
        pix_valid = 1'b1;
        for (n = 0; n < 20 && pix_ready !== 1'b1; n++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        pix_valid = 1'b0;
        pix_data = ~pix_data;
        for (n = 0; n < 20 && vid_valid !== 1'b1; n++)
            @(negedge clk_sys);
        chk("video", e, vid);
        vid_ready = 1'b1;
        @(negedge clk_sys);
        vid_ready = 1'b0;
    endtask

    task automatic t_reset();
        rd(PW, 8'h00);
        rd(PR, 8'h00);
        chk("video", 8'h00, vid);
        $display("t_reset done");
    endtask

    task automatic t_toggle();
        wr(PW, 8'h30);
        wr(PW, 8'ha5);
        rd(PR, 8'ha5);
        rd(PR, 8'ha5);
        wr(PW, 8'h31);
        wr(PW, 8'h3c);
        rd(PW, 8'h31);
        rd(PR, 8'h3c);
        wr(PW, 8'h30);
        stat(VGAAC_STAT_MONO);
        wr(PW, 8'h32);
        rd(PW, 8'h32);
        wr(PW, 8'h0f);
        wr(PR, 8'hff);
        rd(PR, 8'h0f);
        misc_color_emul = 1'b1;
        wr(PW, 8'h30);
        stat(VGAAC_STAT_MONO);
        wr(PW, 8'h33);
        rd(PR, 8'h33);
        wr(PW, 8'h31);
        stat(VGAAC_STAT_COLOR);
        wr(PW, 8'h30);
        rd(PW, 8'h30);
        stat(VGAAC_STAT_COLOR);
        host.idle();
        misc_color_emul = 1'b0;
        $display("t_toggle done");
    endtask

    task automatic t_regs();
        logic [7:0] ix [6] = '{8'h23, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
        logic [7:0] ex [6] = '{8'h3f, 8'hff, 8'h3f, 8'h0f, 8'h0f, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            wreg(ix[i], 8'hff);
            rd(PR, ex[i]);
        end
        $display("t_regs done");
    endtask

    task automatic t_video();
        logic [1:0] sx [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
        wreg(8'h25, 8'h2a);
        wreg(8'h21, 8'h15);
        wreg(8'h32, 8'h0f);
        wreg(8'h34, 8'h0c);
        wreg(8'h30, 8'h00);
        wreg(8'h31, 8'h5a);
        dot(4'h5, 1'b0, 8'h00, 1'b0, 1'b0, 8'hea);
        for (int k = 0; k < 4; k++)
        begin
            wreg(8'h32, {2'h0, k[1:0], 4'hf});
            dot(4'h5, 1'b0, 8'h00, 1'b0, 1'b0, 8'hea);
            chk("status", {6'h00, sx[k]}, {6'h00, stat_bits});
        end
        wreg(8'h34, 8'h0d);
        wreg(8'h30, 8'h80);
        dot(4'h5, 1'b0, 8'h00, 1'b0, 1'b0, 8'hda);
        wreg(8'h32, 8'h01);
        dot(4'h5, 1'b0, 8'h00, 1'b0, 1'b0, 8'hd5);
        dot(4'h5, 1'b1, 8'h00, 1'b0, 1'b0, 8'h5a);
        wreg(8'h30, 8'h40);
        dot(4'h5, 1'b0, 8'h77, 1'b0, 1'b0, 8'h77);
        wr(PW, 8'h05);
        host.idle();
        dot(4'h5, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00);
        stat(VGAAC_STAT_MONO);
        host.idle();
        $display("t_video done");
    endtask

    task automatic t_pan();
        wreg(8'h33, 8'h05);
        wreg(8'h30, 8'h20);
        chk("pan", 8'h05, {4'h0, pan_shift});
        dot(4'h0, 1'b1, 8'h00, 1'b1, 1'b0, 8'h5a);
        chk("pan", 8'h00, {4'h0, pan_shift});
        dot(4'h0, 1'b1, 8'h00, 1'b0, 1'b1, 8'h5a);
        chk("pan", 8'h05, {4'h0, pan_shift});
        wreg(8'h31, 8'h00);
        rd(PR, 8'h00);
        $display("t_pan done");
    endtask

    // fill with the far side stalled, then drain
    task automatic t_fill();
        int an;
        int on;
        an = 0;
        on = 0;
        pix_data = '{4'h5, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        pix_valid = 1'b1;
        repeat (14)
        begin
            if (pix_ready === 1'b1)
                an++;
            @(negedge clk_sys);
        end
        pix_valid = 1'b0;
        chk("pix_ready", 8'h00, {7'h00, pix_ready});
        chk("fill", 8'h01, {7'h00, an >= VGAAC_FIFO_DEPTH});
        vid_ready = 1'b1;
        repeat (20)
        begin
            if (vid_valid === 1'b1)
                on++;
            @(negedge clk_sys);
        end
        vid_ready = 1'b0;
        chk("drained", an[7:0], on[7:0]);
        $display("t_fill done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #(5000 * 50);
        num_errors++;
        $display("watchdog expired");
        close_out();
    end

    initial
    begin
        repeat (16) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_toggle();
        t_regs();
        t_video();
        t_pan();
        t_fill();
        close_out();
    end
endmodule
